/* File: hdl/ales_pkg.sv */
// Constants, register map and types of the arithmetic and logic slice
package ales_pkg;
   // Byte offsets of the bus registers
   localparam logic [4:0] ADDR_CTRL  = 5'h00;
   localparam logic [4:0] ADDR_DST   = 5'h04;
   localparam logic [4:0] ADDR_SRC   = 5'h08;
   localparam logic [4:0] ADDR_IMM   = 5'h0c;
   localparam logic [4:0] ADDR_FLAGS = 5'h10;
   // Word index of each register (byte address bits 4:2)
   localparam logic [2:0] IDX_CTRL   = 3'h0;
   localparam logic [2:0] IDX_DST    = 3'h1;
   localparam logic [2:0] IDX_SRC    = 3'h2;
   localparam logic [2:0] IDX_IMM    = 3'h3;
   localparam logic [2:0] IDX_FLAGS  = 3'h4;
   // Field positions
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OP_W   = 4;
   localparam int CTRL_GO_BIT = 8;
   localparam int FLAG_C      = 0;
   localparam int FLAG_Z      = 1;
   localparam int FLAG_N      = 2;
   localparam int FLAG_V      = 3;
   localparam int FLAG_S      = 4;
   localparam int FLAG_H      = 5;
   localparam int FLAG_W      = 6;
   // Reset values
   localparam logic [15:0]       DST_RST   = 16'h0000;
   localparam logic [7:0]        SRC_RST   = 8'h00;
   localparam logic [7:0]        IMM_RST   = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
   localparam logic [31:0]       RDATA_RST = 32'h0000_0000;

   typedef enum logic [3:0] {
      OP_SUM       = 4'h0,
      OP_CSUM      = 4'h1,
      OP_WSUM      = 4'h2,
      OP_DIFF      = 4'h3,
      OP_IDIFF     = 4'h4,
      OP_BDIFF     = 4'h5,
      OP_IBDIFF    = 4'h6,
      OP_WDIFF     = 4'h7,
      OP_AND       = 4'h8,
      OP_MASK      = 4'h9
   } ales_op_t;

   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_EXEC1 = 2'b01,
      S_EXEC2 = 2'b10
   } ales_state_t;
endpackage : ales_pkg

/* File: hdl/ales_addsub_if.sv */
// Operand and result bundle between the slice and its adder
`timescale 1ns/10ps
`default_nettype none
interface ales_addsub_if;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   logic       sub;
   logic [7:0] sum;
   logic       cout;
   logic       half;
   logic       ovf;
   modport alu  (input a, b, cin, sub, output sum, cout, half, ovf);
   modport user (output a, b, cin, sub, input sum, cout, half, ovf);
endinterface : ales_addsub_if
`default_nettype wire

/* File: hdl/ales_addsub.sv */
// Eight-bit adder and subtractor with carry, half carry and overflow
`timescale 1ns/10ps
`default_nettype none
module ales_addsub (
   ales_addsub_if.alu p
);
   logic [7:0] bb;
   logic       ci;
   logic [8:0] s9;
   logic [4:0] s5;

   // Subtraction as a + ~b + ~borrow, so borrow is the inverted carry
   assign bb = p.sub ? ~p.b : p.b;
   assign ci = p.sub ? ~p.cin : p.cin;
   assign s9 = {1'b0, p.a} + {1'b0, bb} + {8'h00, ci};
   assign s5 = {1'b0, p.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
   assign p.sum  = s9[7:0];
   assign p.cout = p.sub ? ~s9[8] : s9[8];
   assign p.half = p.sub ? ~s5[4] : s5[4];
   assign p.ovf  = ~(p.a[7] ^ bb[7]) & (p.a[7] ^ s9[7]);
endmodule : ales_addsub
`default_nettype wire

/* File: hdl/ales_top.sv */
// Arithmetic and logic slice with its Avalon-MM register slave
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module ales_top
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest
);
   import ales_pkg::*;

   ales_state_t           st_reg,    st_next;
   ales_op_t              op_reg,    op_next;
   logic [15:0]           dst_reg,   dst_next;
   logic [7:0]            src_reg,   src_next;
   logic [7:0]            imm_reg,   imm_next;
   logic [FLAG_W-1:0]     flags_reg, flags_next;
   logic [7:0]            lo_reg,    lo_next;
   logic                  lc_reg,    lc_next;
   logic                  wait_reg,  wait_next;
   logic [31:0]           rdata_reg, rdata_next;

   logic [31:0]           wmask;
   logic [31:0]           rmux;
   logic [31:0]           m_dst;
   logic [31:0]           m_src;
   logic [31:0]           m_imm;
   logic [31:0]           m_flg;
   logic                  req;
   logic                  wr_acc;
   logic                  go_ok;
   logic                  op_ok;
   logic [2:0]            idx;
   logic [7:0]            and_res;
   logic                  use_imm;
   logic                  word_op;
   logic                  and_op;
   logic [7:0]            dst_lo;
   logic                  c_flag;

   ales_addsub_if au ();

   ales_addsub u_addsub (
      .p (au)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[8*gi +: 8] = {8{avs_byteenable[gi]}};
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [31:0] mk);
      merge = (old & ~mk) | (wd & mk);
   endfunction : merge

   assign idx     = avs_address[4:2];
   assign req     = avs_read | avs_write;
   // A request is taken at the edge where waitrequest is already low
   assign wr_acc  = avs_write & ~wait_reg;
   assign m_dst   = merge({16'h0000, dst_reg}, avs_writedata, wmask);
   assign m_src   = merge({24'h000000, src_reg}, avs_writedata, wmask);
   assign m_imm   = merge({24'h000000, imm_reg}, avs_writedata, wmask);
   assign m_flg   = merge({26'h0000000, flags_reg}, avs_writedata, wmask);
   assign dst_lo  = dst_reg[7:0];
   assign c_flag  = flags_reg[FLAG_C];

   always_comb begin
      case (ales_op_t'(avs_writedata[CTRL_OP_LSB +: CTRL_OP_W]))
         OP_SUM, OP_CSUM, OP_WSUM, OP_DIFF, OP_IDIFF,
         OP_BDIFF, OP_IBDIFF, OP_WDIFF, OP_AND, OP_MASK: op_ok = 1'b1;
         default: op_ok = 1'b0;
      endcase
   end

   // Undefined opcodes never start, so the engine cannot hang
   assign go_ok = wr_acc & (idx == IDX_CTRL) & avs_byteenable[1] &
                  avs_byteenable[0] & avs_writedata[CTRL_GO_BIT] & op_ok;

   always_comb begin
      case (idx)
         IDX_CTRL:  rmux = {28'h0000000, op_reg};
         IDX_DST:   rmux = {16'h0000, dst_reg};
         IDX_SRC:   rmux = {24'h000000, src_reg};
         IDX_IMM:   rmux = {24'h000000, imm_reg};
         IDX_FLAGS: rmux = {26'h0000000, flags_reg};
         default:   rmux = 32'h0000_0000;
      endcase
   end

   // Operand steering into the shared adder
   always_comb begin
      use_imm = 1'b0;
      word_op = 1'b0;
      and_op  = 1'b0;
      au.sub  = 1'b0;
      au.cin  = 1'b0;
      case (op_reg)
         OP_SUM:    au.sub = 1'b0;
         OP_CSUM:   au.cin = c_flag;
         OP_WSUM:   word_op = 1'b1;
         OP_DIFF:   au.sub = 1'b1;
         OP_IDIFF: begin
            au.sub  = 1'b1;
            use_imm = 1'b1;
         end
         OP_BDIFF: begin
            au.sub = 1'b1;
            au.cin = c_flag;
         end
         OP_IBDIFF: begin
            au.sub  = 1'b1;
            au.cin  = c_flag;
            use_imm = 1'b1;
         end
         OP_WDIFF: begin
            au.sub  = 1'b1;
            word_op = 1'b1;
         end
         OP_AND:    and_op = 1'b1;
         OP_MASK: begin
            and_op  = 1'b1;
            use_imm = 1'b1;
         end
         default:   and_op = 1'b0;
      endcase
      au.a = dst_lo;
      au.b = (use_imm | word_op) ? imm_reg : src_reg;
      // Second word step: high byte plus the low step's carry or borrow
      if (st_reg == S_EXEC2) begin
         au.a   = dst_reg[15:8];
         au.b   = 8'h00;
         au.cin = lc_reg;
      end
   end

   assign and_res = dst_lo & au.b;

   always_comb begin
      st_next    = st_reg;
      op_next    = op_reg;
      dst_next   = dst_reg;
      src_next   = src_reg;
      imm_next   = imm_reg;
      flags_next = flags_reg;
      lo_next    = lo_reg;
      lc_next    = lc_reg;
      wait_next  = 1'b1;
      rdata_next = rdata_reg;
      // Registers stall behind waitrequest while an operation runs
      if (req && wait_reg && st_reg == S_IDLE) begin
         wait_next  = 1'b0;
         rdata_next = rmux;
      end
      if (wr_acc) begin
         case (idx)
            IDX_DST:   dst_next   = m_dst[15:0];
            IDX_SRC:   src_next   = m_src[7:0];
            IDX_IMM:   imm_next   = m_imm[7:0];
            IDX_FLAGS: flags_next = m_flg[FLAG_W-1:0];
            default:   dst_next   = dst_reg;
         endcase
      end
      if (go_ok) begin
         op_next = ales_op_t'(avs_writedata[CTRL_OP_LSB +: CTRL_OP_W]);
         st_next = S_EXEC1;
      end
      case (st_reg)
         S_IDLE: st_next = st_next;
         S_EXEC1: begin
            if (word_op) begin
               lo_next = au.sum;
               lc_next = au.cout;
               st_next = S_EXEC2;
            end else if (and_op) begin
               dst_next[7:0]      = and_res;
               flags_next[FLAG_Z] = (and_res == 8'h00);
               flags_next[FLAG_N] = and_res[7];
               flags_next[FLAG_V] = 1'b0;
               st_next            = S_IDLE;
            end else begin
               dst_next[7:0]      = au.sum;
               flags_next[FLAG_Z] = (au.sum == 8'h00);
               flags_next[FLAG_C] = au.cout;
               flags_next[FLAG_N] = au.sum[7];
               flags_next[FLAG_V] = au.ovf;
               flags_next[FLAG_H] = au.half;
               st_next            = S_IDLE;
            end
         end
         S_EXEC2: begin
            // high byte step and word flags
            dst_next           = {au.sum, lo_reg};
            flags_next[FLAG_Z] = ({au.sum, lo_reg} == 16'h0000);
            flags_next[FLAG_C] = au.cout;
            flags_next[FLAG_N] = au.sum[7];
            flags_next[FLAG_V] = au.ovf;
            flags_next[FLAG_S] = au.sum[7] ^ au.ovf;
            st_next            = S_IDLE;
         end
         default: st_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg    <= S_IDLE;
         op_reg    <= OP_SUM;
         dst_reg   <= DST_RST;
         src_reg   <= SRC_RST;
         imm_reg   <= IMM_RST;
         flags_reg <= FLAGS_RST;
         lo_reg    <= 8'h00;
         lc_reg    <= 1'b0;
         wait_reg  <= 1'b1;
         rdata_reg <= RDATA_RST;
      end else begin
         st_reg    <= st_next;
         op_reg    <= op_next;
         dst_reg   <= dst_next;
         src_reg   <= src_next;
         imm_reg   <= imm_next;
         flags_reg <= flags_next;
         lo_reg    <= lo_next;
         lc_reg    <= lc_next;
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_byte(ales_op_t o);
      st_reg == S_EXEC1 && op_reg == o;
   endsequence
   sequence s_word(ales_op_t o);
      (st_reg == S_EXEC1 && op_reg == o) ##1 (st_reg == S_EXEC2);
   endsequence

   sum_commit_a: assert property (s_byte(OP_SUM) |=>
      st_reg == S_IDLE && dst_lo == $past(dst_lo) + $past(src_reg))
      else $error("sum result wrong");
   carry_sum_a: assert property (s_byte(OP_CSUM) |=>
      dst_lo == $past(dst_lo) + $past(src_reg) + {7'h00, $past(c_flag)})
      else $error("carry sum result wrong");
   word_sum_a: assert property (s_word(OP_WSUM) |=>
      st_reg == S_IDLE && flags_reg[FLAG_S] ==
      (flags_reg[FLAG_N] ^ flags_reg[FLAG_V]) &&
      dst_reg == $past(dst_reg, 2) + {8'h00, $past(imm_reg, 2)})
      else $error("word sum wrong");
   diff_commit_a: assert property (s_byte(OP_DIFF) |=>
      dst_lo == $past(dst_lo) - $past(src_reg) &&
      flags_reg[FLAG_C] == ($past(src_reg) > $past(dst_lo)))
      else $error("difference wrong");
   imm_diff_a: assert property (s_byte(OP_IDIFF) |=>
      dst_lo == $past(dst_lo) - $past(imm_reg) &&
      flags_reg[FLAG_Z] == (dst_lo == 8'h00))
      else $error("immediate difference wrong");
   borrow_diff_a: assert property (s_byte(OP_BDIFF) |=>
      dst_lo == $past(dst_lo) - $past(src_reg) - {7'h00, $past(c_flag)})
      else $error("borrow difference wrong");
   imm_borrow_a: assert property (s_byte(OP_IBDIFF) |=>
      dst_lo == $past(dst_lo) - $past(imm_reg) - {7'h00, $past(c_flag)})
      else $error("immediate borrow difference wrong");
   word_diff_a: assert property (s_word(OP_WDIFF) |=>
      dst_reg == $past(dst_reg, 2) - {8'h00, $past(imm_reg, 2)} &&
      $stable(flags_reg[FLAG_H]))
      else $error("word difference wrong");
   and_commit_a: assert property (s_byte(OP_AND) |=>
      dst_lo == ($past(dst_lo) & $past(src_reg)) && !flags_reg[FLAG_V])
      else $error("and result wrong");
   mask_commit_a: assert property (s_byte(OP_MASK) |=>
      dst_lo == ($past(dst_lo) & $past(imm_reg)) &&
      flags_reg[FLAG_N] == dst_lo[7])
      else $error("mask result wrong");
   flags_kept_a: assert property ((st_reg == S_EXEC1 && and_op) |=>
      $stable(flags_reg[FLAG_C]) && $stable(flags_reg[FLAG_H]) &&
      $stable(flags_reg[FLAG_S]))
      else $error("logic op changed other flags");
   sign_kept_a: assert property ((st_reg == S_EXEC1 && !and_op &&
      !word_op) |=> $stable(flags_reg[FLAG_S]) && $stable(dst_reg[15:8]))
      else $error("byte op changed sign flag");
endmodule : ales_top
`default_nettype wire

/* File: tb/ales_host_model.sv */
// Bus master model standing in for the decoder and register file
`timescale 1ns/10ps
`default_nettype none
module ales_host_model (
   input  wire logic        clk,
   output var  logic [4:0]  avs_address,
   output var  logic        avs_read,
   output var  logic        avs_write,
   output var  logic [31:0] avs_writedata,
   output var  logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address    = 5'h00;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0000_0000;
      avs_byteenable = 4'h0;
   end

   // One transfer; n counts edges until taken, no limit of its own
   task automatic xfer(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q, output int n);
      n = 0;
      @(posedge clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= wr;
      avs_read       <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      // Released address and data lines show the inverse so stale values cannot pass
      avs_address    <= ~a;
      avs_writedata  <= ~d;
   endtask : xfer
endmodule : ales_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the arithmetic and logic slice
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import ales_pkg::*;
   logic        clk   = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  address;
   logic        rd_en;
   logic        wr_en;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] rdata;
   logic        wait_req;
   int          fail_count = 0;
   int          n_checks   = 0;
   logic [31:0] rng        = 32'hace905a0;

   always #25 clk = ~clk;

   ales_top dut (.clk(clk), .rst_n(rst_n), .avs_address(address),
      .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
      .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wait_req));

   ales_host_model host (.clk(clk), .avs_address(address),
      .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
      .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wait_req));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : xs

   // Expected {pair, flags} after one operation
   function automatic logic [21:0] model(input logic [3:0] op,
      input logic [15:0] d, input logic [7:0] s, input logic [7:0] k,
      input logic [5:0] f);
      logic [7:0]  b;
      logic [8:0]  r;
      logic [4:0]  h;
      logic [16:0] w;
      logic        sub;
      logic        c;
      logic        v;
      logic [15:0] dn;
      logic [5:0]  fn;
      dn  = d;
      fn  = f;
      b   = (op inside {OP_IDIFF, OP_IBDIFF, OP_MASK}) ? k : s;
      sub = op inside {OP_DIFF, OP_IDIFF, OP_BDIFF, OP_IBDIFF};
      c   = (op inside {OP_CSUM, OP_BDIFF, OP_IBDIFF}) & f[FLAG_C];
      if (op == OP_WSUM || op == OP_WDIFF) begin
         w  = (op == OP_WSUM) ? {1'b0, d} + k : {1'b0, d} - k;
         v  = (op == OP_WSUM) ? (~d[15] & w[15]) : (d[15] & ~w[15]);
         dn = w[15:0];
         fn[FLAG_C] = w[16];
         fn[FLAG_Z] = (w[15:0] == 16'h0000);
         fn[FLAG_N] = w[15];
         fn[FLAG_V] = v;
         fn[FLAG_S] = w[15] ^ v;
      end else if (op == OP_AND || op == OP_MASK) begin
         dn[7:0]    = d[7:0] & b;
         fn[FLAG_Z] = (dn[7:0] == 8'h00);
         fn[FLAG_N] = dn[7];
         fn[FLAG_V] = 1'b0;
      end else begin
         r = sub ? {1'b0, d[7:0]} - b - c : {1'b0, d[7:0]} + b + c;
         h = sub ? {1'b0, d[3:0]} - b[3:0] - c : {1'b0, d[3:0]} + b[3:0] + c;
         v = sub ? (d[7] != b[7]) && (r[7] != d[7])
                 : (d[7] == b[7]) && (r[7] != d[7]);
         dn[7:0]    = r[7:0];
         fn[FLAG_C] = r[8];
         fn[FLAG_Z] = (r[7:0] == 8'h00);
         fn[FLAG_N] = r[7];
         fn[FLAG_V] = v;
         fn[FLAG_H] = h[4];
      end
      return {dn, fn};
   endfunction : model

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] e);
      logic [31:0] q;
      int          n;
      host.xfer(1'b1, a, d, e, q, n);
   endtask : wr

   task automatic conclude();
      $display("checks=%0d errors=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude();
   end

   initial begin
      logic [31:0] q;
      int          n;
      logic [15:0] d;
      logic [7:0]  s;
      logic [7:0]  k;
      logic [5:0]  f;
      logic [3:0]  op;
      logic [21:0] e;
      int          nx;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Reset values, unmapped place included
      for (int a = 0; a < 6; a++) begin
         host.xfer(1'b0, 5'(a * 4), 32'h0, 4'hf, q, n);
         chk(q, 32'h0000_0000);
      end
      wr(5'h14, 32'hffff_ffff, 4'hf);
      host.xfer(1'b0, 5'h14, 32'h0, 4'hf, q, n);
      chk(q, 32'h0000_0000);
      // Lane merge, then an opcode that must start nothing
      wr(ADDR_DST, 32'h0000_a55a, 4'hf);
      wr(ADDR_DST, 32'h0000_3cc3, 4'h1);
      wr(ADDR_CTRL, 32'h0000_010f, 4'hf);
      // Go without both low lanes must not start either
      wr(ADDR_CTRL, 32'h0000_0108, 4'h1);
      host.xfer(1'b0, ADDR_DST, 32'h0, 4'hf, q, n);
      chk(q, 32'h0000_a5c3);
      host.xfer(1'b0, ADDR_CTRL, 32'h0, 4'hf, q, n);
      chk(q, 32'h0000_0000);
      for (int i = 0; i < 60; i++) begin
         op = 4'(i % 10);
         if (i < 10) begin
            {d, s, k, f} = {16'hffff, 8'h01, 8'hff, 6'h3f};
         end else if (i < 20) begin
            {d, s, k, f} = {16'h7f80, 8'h80, 8'h80, 6'h00};
         end else begin
            q = xs();
            {k, s, d} = q;
            q = xs();
            f = q[5:0];
         end
         wr(ADDR_DST, {16'h0000, d}, 4'hf);
         wr(ADDR_SRC, {24'h0, s}, 4'hf);
         wr(ADDR_IMM, {24'h0, k}, 4'hf);
         wr(ADDR_FLAGS, {26'h0, f}, 4'hf);
         wr(ADDR_CTRL, 32'h0000_0100 | 32'(op), 4'hf);
         e = model(op, d, s, k, f);
         // Read raised after the go edge: one wait cycle plus a word stall
         nx = (op inside {OP_WSUM, OP_WDIFF}) ? 3 : 2;
         host.xfer(1'b0, ADDR_DST, 32'h0, 4'hf, q, n);
         chk(q, {16'h0000, e[21:6]});
         chk(32'(n), 32'(nx));
         host.xfer(1'b0, ADDR_FLAGS, 32'h0, 4'hf, q, n);
         chk(q, {26'h0, e[5:0]});
         host.xfer(1'b0, ADDR_CTRL, 32'h0, 4'hf, q, n);
         chk(q, {28'h0, op});
      end
      conclude();
   end
endmodule : testbench
`default_nettype wire
